/* File: common/uibc_pkg.sv */
// Purpose: shared constants for the in-endpoint descriptor block
// Assumes: APB with 32-bit data, one system clock, synchronous reset
// Notes: every descriptor byte sits in the low byte of its own word
package uibc_pkg;

    // geometry
    localparam int EP_NUM = 8;
    localparam int EP_W = 3;
    localparam int CNT_W = 7;
    localparam int BPS_W = 5;
    localparam int ADDR_W = 11;
    localparam int ALIGN_BITS = 3;
    localparam int LEN_W = 12;
    localparam int PADDR_W = 12;

    // descriptor byte index inside one endpoint block of eight words
    localparam logic [2:0] REG_SECOND_COUNT = 3'h0;
    localparam logic [2:0] REG_SECOND_BASE = 3'h1;
    localparam logic [2:0] REG_FIRST_COUNT = 3'h2;
    localparam logic [2:0] REG_BUF_SIZE = 3'h3;
    localparam logic [2:0] REG_FIRST_BASE = 3'h4;
    localparam logic [2:0] REG_CONFIG = 3'h5;

    // byte addresses: endpoint e, byte b at e*0x20 + b*4
    localparam logic [PADDR_W-1:0] EP_REGION_END = 12'h100;
    localparam logic [PADDR_W-1:0] IRQ_STATUS_OFF = 12'h100;
    localparam logic [PADDR_W-1:0] IRQ_MASK_OFF = 12'h104;

    // field positions
    localparam int EMPTY_BIT = 7;
    localparam int CFG_ISO_BIT = 6;
    localparam int CFG_DUAL_BUFFER_SELECT_BIT = 4;
    localparam int BPS_LSB = 0;

    // reset value of every descriptor and control byte
    localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage

/* File: hdl/uibc_addr_form.sv */
// Purpose: 11-bit buffer start address from a base byte
// Assumes: base byte holds address bits 10:3
// Notes: low bits forced to zero, eight-byte alignment
`timescale 1ns/1ps
module uibc_addr_form import uibc_pkg::*; (
    // base byte
    input wire logic [7:0] base_byte,
    // start address
    output logic [ADDR_W-1:0] start_addr
);
    assign start_addr = {base_byte, {ALIGN_BITS{1'b0}}};

endmodule // uibc_addr_form

/* File: hdl/uibc_len_calc.sv */
// Purpose: packet byte length from a 7-bit count
// Assumes: bytes-per-sample field holds bytes minus one
// Notes: purely combinational
`timescale 1ns/1ps
module uibc_len_calc import uibc_pkg::*; (
    // descriptor fields
    input wire logic [CNT_W-1:0] count,
    input wire logic [BPS_W-1:0] bps_field,
    input wire logic iso,
    // result
    output logic [LEN_W-1:0] byte_len
);
    logic [BPS_W:0] bytes_per_sample;
    logic [CNT_W+BPS_W:0] product;

    always_comb begin
        bytes_per_sample = {1'b0, bps_field} + 6'h01;
        product = count * bytes_per_sample;
        if (iso) begin
            byte_len = product[LEN_W-1:0];
        end else begin
            byte_len = {{(LEN_W-CNT_W){1'b0}}, count};
        end
    end

endmodule // uibc_len_calc

/* File: hdl/uibc_top.sv */
// Purpose: in-endpoint descriptor bytes and buffer-empty handshake decisions
// Assumes: token and done strobes come from same-clock buffer-manager logic
// Notes: descriptor bytes reached over APB; one answer per token, one cycle later
`timescale 1ns/1ps

// Contract
// - Each in endpoint owns a block of eight descriptor bytes.
// - Control endpoint plus up to seven in endpoints, each with own bytes.
// - Successful transaction draining the second buffer sets its empty flag bit 7.
// - Successful transaction draining the first buffer sets its empty flag bit 7.
// - Non-isochronous endpoint with empty flag set answers every token with NAK.
// - Isochronous endpoint never NAKs and ignores the empty flag.
// - The count means bytes, or samples for isochronous endpoints.
// - Isochronous byte length is sample count times bytes per sample.
// - Buffer start is 11 bits; base byte holds address bits 10:3.
// - Three low address bits are forced to zero.
// - Bytes-per-sample field encodes bytes minus one, 1 to 32.
// - Without dual buffering only the first buffer is used.
// - Both buffers share one size in 8-byte units.
// - Endpoint is isochronous only when its iso select bit is 1.
module uibc_top import uibc_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // usb buffer manager token and answer
    input wire logic in_tok_valid,
    input wire logic [EP_W-1:0] in_tok_ep,
    output logic resp_valid,
    output logic resp_nak,
    output logic resp_buf_y,
    output logic [ADDR_W-1:0] resp_addr,
    output logic [LEN_W-1:0] resp_len,
    // usb buffer manager transaction done
    input wire logic in_done_valid,
    input wire logic [EP_W-1:0] in_done_ep,
    // interrupt
    output logic irq
);
    // all block state in one register
    typedef struct packed {
        logic [EP_NUM-1:0][7:0] cfg;
        logic [EP_NUM-1:0][7:0] base_x;
        logic [EP_NUM-1:0][7:0] base_y;
        logic [EP_NUM-1:0][7:0] cnt_x;
        logic [EP_NUM-1:0][7:0] cnt_y;
        logic [EP_NUM-1:0][7:0] buf_size;
        logic [EP_NUM-1:0] use_y;
        logic [EP_NUM-1:0] irq_stat;
        logic [EP_NUM-1:0] irq_mask;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic resp_valid;
        logic resp_nak;
        logic resp_buf_y;
        logic [ADDR_W-1:0] resp_addr;
        logic [LEN_W-1:0] resp_len;
        logic irq;
    } uibc_state_s;

    uibc_state_s state_q;
    uibc_state_s state_d;

    // descriptor of the endpoint a token names
    logic tok_iso;
    logic tok_dual_buffer_select;
    logic tok_sel_y;
    logic [7:0] tok_cnt;
    logic [7:0] tok_base;
    logic [ADDR_W-1:0] tok_addr;
    logic [LEN_W-1:0] tok_len;

    // decode shared by bus checks and writes
    function automatic logic addr_mapped(input logic [PADDR_W-1:0] a);
        logic ok;
        ok = 1'b0;
        if (a == IRQ_STATUS_OFF || a == IRQ_MASK_OFF) begin
            ok = 1'b1;
        end else if (a < EP_REGION_END && a[1:0] == 2'b00) begin
            ok = (a[4:2] == REG_SECOND_COUNT) || (a[4:2] == REG_SECOND_BASE) ||
                 (a[4:2] == REG_FIRST_COUNT) || (a[4:2] == REG_FIRST_BASE) ||
                 (a[4:2] == REG_BUF_SIZE) ||
                 (a[4:2] == REG_CONFIG);
        end
        return ok;
    endfunction

    function automatic logic [7:0] reg_read(input uibc_state_s s, input logic [PADDR_W-1:0] a);
        logic [7:0] v;
        logic [EP_W-1:0] e;
        v = BYTE_RESET;
        e = a[7:5];
        if (a == IRQ_STATUS_OFF) begin
            v = s.irq_stat;
        end else if (a == IRQ_MASK_OFF) begin
            v = s.irq_mask;
        end else if (a < EP_REGION_END) begin
            unique case (a[4:2])
                REG_SECOND_COUNT: v = s.cnt_y[e];
                REG_SECOND_BASE: v = s.base_y[e];
                REG_FIRST_COUNT: v = s.cnt_x[e];
                REG_FIRST_BASE: v = s.base_x[e];
                REG_BUF_SIZE: v = s.buf_size[e];
                REG_CONFIG: v = s.cfg[e];
                default: v = BYTE_RESET;
            endcase
        end
        return v;
    endfunction

    // token-side selection from the current descriptor
    always_comb begin
        tok_iso = state_q.cfg[in_tok_ep][CFG_ISO_BIT];
        tok_dual_buffer_select = state_q.cfg[in_tok_ep][CFG_DUAL_BUFFER_SELECT_BIT];
        tok_sel_y = tok_dual_buffer_select && state_q.use_y[in_tok_ep];
        tok_cnt = tok_sel_y ? state_q.cnt_y[in_tok_ep] : state_q.cnt_x[in_tok_ep];
        tok_base = tok_sel_y ? state_q.base_y[in_tok_ep] : state_q.base_x[in_tok_ep];
    end

    uibc_len_calc u_len_calc (
        .count(tok_cnt[CNT_W-1:0]),
        .bps_field(state_q.cfg[in_tok_ep][BPS_LSB +: BPS_W]),
        .iso(tok_iso),
        .byte_len(tok_len)
    );

    uibc_addr_form u_addr_form (
        .base_byte(tok_base),
        .start_addr(tok_addr)
    );

    always_comb begin
        logic apb_wr;
        logic done_y;
        logic [EP_W-1:0] we;
        apb_wr = 1'b0;
        done_y = 1'b0;
        we = paddr[7:5];
        state_d = state_q;
        state_d.pready = 1'b0;
        state_d.resp_valid = 1'b0;

        // apb: one wait state, answer on the second access cycle
        if (psel && penable && !state_q.pready) begin
            state_d.pready = 1'b1;
            state_d.pslverr = !addr_mapped(paddr);
            state_d.prdata = {24'h000000, reg_read(state_q, paddr)};
        end
        apb_wr = psel && penable && state_q.pready && pwrite && addr_mapped(paddr);
        if (apb_wr) begin
            if (paddr == IRQ_STATUS_OFF) begin
                state_d.irq_stat = state_q.irq_stat & ~pwdata[EP_NUM-1:0];
            end else if (paddr == IRQ_MASK_OFF) begin
                state_d.irq_mask = pwdata[EP_NUM-1:0];
            end else begin
                unique case (paddr[4:2])
                    REG_SECOND_COUNT: state_d.cnt_y[we] = pwdata[7:0];
                    REG_SECOND_BASE: state_d.base_y[we] = pwdata[7:0];
                    REG_FIRST_COUNT: state_d.cnt_x[we] = pwdata[7:0];
                    REG_FIRST_BASE: state_d.base_x[we] = pwdata[7:0];
                    REG_BUF_SIZE: state_d.buf_size[we] = pwdata[7:0];
                    REG_CONFIG: state_d.cfg[we] = pwdata[7:0];
                    default: state_d.cfg[we] = state_q.cfg[we];
                endcase
            end
        end

        // answer to a token, one cycle later
        if (in_tok_valid) begin
            state_d.resp_valid = 1'b1;
            state_d.resp_buf_y = tok_sel_y;
            state_d.resp_nak = !tok_iso && tok_cnt[EMPTY_BIT];
            state_d.resp_addr = tok_addr;
            state_d.resp_len = tok_len;
        end

        // done after software writes, so the hardware set wins
        if (in_done_valid) begin
            done_y = state_q.cfg[in_done_ep][CFG_DUAL_BUFFER_SELECT_BIT] && state_q.use_y[in_done_ep];
            if (done_y) begin
                state_d.cnt_y[in_done_ep][EMPTY_BIT] = 1'b1;
            end else begin
                state_d.cnt_x[in_done_ep][EMPTY_BIT] = 1'b1;
            end
            state_d.use_y[in_done_ep] = state_q.cfg[in_done_ep][CFG_DUAL_BUFFER_SELECT_BIT] &&
                                        !state_q.use_y[in_done_ep];
            state_d.irq_stat[in_done_ep] = 1'b1;
        end

        state_d.irq = |(state_d.irq_stat & state_d.irq_mask);
    end

    // reset clears every byte and restarts each selector at the first buffer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign prdata = state_q.prdata;
    assign pready = state_q.pready;
    assign pslverr = state_q.pslverr;
    assign resp_valid = state_q.resp_valid;
    assign resp_nak = state_q.resp_nak;
    assign resp_buf_y = state_q.resp_buf_y;
    assign resp_addr = state_q.resp_addr;
    assign resp_len = state_q.resp_len;
    assign irq = state_q.irq;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_nak_when_empty: assert property (
        in_tok_valid && !tok_iso && tok_cnt[EMPTY_BIT] |=> resp_valid && resp_nak)
        else $error("empty non-iso endpoint not answered with nak");

    a_iso_never_nak: assert property (
        in_tok_valid && tok_iso |=> resp_valid && !resp_nak)
        else $error("isochronous endpoint answered with nak");

    a_first_flag_set: assert property (
        in_done_valid && !(state_q.cfg[in_done_ep][CFG_DUAL_BUFFER_SELECT_BIT] && state_q.use_y[in_done_ep])
        |=> state_q.cnt_x[$past(in_done_ep)][EMPTY_BIT])
        else $error("first buffer empty flag not set");

    a_second_flag_set: assert property (
        in_done_valid && state_q.cfg[in_done_ep][CFG_DUAL_BUFFER_SELECT_BIT] && state_q.use_y[in_done_ep]
        |=> state_q.cnt_y[$past(in_done_ep)][EMPTY_BIT] && !state_q.use_y[$past(in_done_ep)])
        else $error("second buffer empty flag not set");

    a_addr_aligned: assert property (
        resp_valid |-> resp_addr[ALIGN_BITS-1:0] == '0 && resp_addr[ADDR_W-1:ALIGN_BITS] == $past(tok_base))
        else $error("buffer start address misformed");

    a_single_first: assert property (
        in_tok_valid && !tok_dual_buffer_select |=> !resp_buf_y)
        else $error("second buffer used without dual buffering");

    a_alternate_buf: assert property (
        in_done_valid && state_q.cfg[in_done_ep][CFG_DUAL_BUFFER_SELECT_BIT] && !state_q.use_y[in_done_ep]
        |=> state_q.use_y[$past(in_done_ep)])
        else $error("dual buffer did not move to second buffer");

    a_iso_length: assert property (
        in_tok_valid && tok_iso |=> resp_len == LEN_W'(LEN_W'($past(tok_cnt[CNT_W-1:0])) *
            (LEN_W'($past(state_q.cfg[in_tok_ep][BPS_LSB +: BPS_W])) + LEN_W'(1))))
        else $error("isochronous length is not count times sample size");

    a_byte_length: assert property (
        in_tok_valid && !tok_iso |=> resp_len == LEN_W'($past(tok_cnt[CNT_W-1:0])))
        else $error("byte length differs from count");

    a_apb_one_wait: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not after exactly one wait state");

    // done side, token answer and bus
    a_single_done: assert property (
        in_done_valid && !state_q.cfg[in_done_ep][CFG_DUAL_BUFFER_SELECT_BIT]
        |=> !state_q.use_y[$past(in_done_ep)] && state_q.cnt_x[$past(in_done_ep)][EMPTY_BIT])
        else $error("single buffer done touched the second buffer");

    a_done_status: assert property (
        in_done_valid |=> state_q.irq_stat[$past(in_done_ep)])
        else $error("done did not set its status bit");

    a_irq_from_done: assert property (
        in_done_valid |=> !state_q.irq_mask[$past(in_done_ep)] || irq)
        else $error("unmasked done did not raise the interrupt");

    a_nak_only_empty: assert property (
        in_tok_valid && !tok_cnt[EMPTY_BIT] |=> resp_valid && !resp_nak)
        else $error("nak answered with data in the buffer");

    a_apb_read_zero: assert property (
        pready |-> prdata[31:8] == '0)
        else $error("read data upper bits not zero");

    // scenario covers
    c_nak_answer: cover property (resp_valid && resp_nak);
    c_iso_send: cover property (in_tok_valid && tok_iso ##1 resp_valid);
    c_dual_both: cover property (resp_valid && resp_buf_y);
    c_irq_raised: cover property (!irq ##1 irq);
    c_apb_error: cover property (pready && pslverr);

endmodule // uibc_top

/* File: verif/uibc_host_model.sv */
// Purpose: far-side buffer manager strobes, token and done
// Assumes: one system clock, strobes launched just after a rising edge
// Notes: endpoint lines show the inverse of the last value while idle
`timescale 1ns/1ps
module uibc_host_model import uibc_pkg::*; (
    // clock
    input wire logic sys_clk,
    // strobes
    output logic in_tok_valid,
    output logic [EP_W-1:0] in_tok_ep,
    output logic in_done_valid,
    output logic [EP_W-1:0] in_done_ep,
    // answer
    input wire logic resp_valid
);
    initial begin
        in_tok_valid = 1'b0;
        in_tok_ep = '0;
        in_done_valid = 1'b0;
        in_done_ep = '0;
    end
    task automatic tok(input logic [EP_W-1:0] ep, output logic got);
        @(posedge sys_clk);
        in_tok_valid <= 1'b1;
        in_tok_ep <= ep;
        @(posedge sys_clk);
        in_tok_valid <= 1'b0;
        in_tok_ep <= ~ep;
        #1 got = resp_valid;
    endtask
    // done only after data went out, never after a nak
    task automatic done(input logic [EP_W-1:0] ep);
        @(posedge sys_clk);
        in_done_valid <= 1'b1;
        in_done_ep <= ep;
        @(posedge sys_clk);
        in_done_valid <= 1'b0;
        in_done_ep <= ~ep;
    endtask
endmodule // uibc_host_model

/* File: verif/uibc_top_tb_top.sv */
// Purpose: directed bench for the in-endpoint descriptor block
// Assumes: one wait state on apb, answer one cycle after a token
// Notes: software writes stand in for the local processor
`timescale 1ns/1ps
module uibc_top_tb_top import uibc_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, in_tok_valid, in_done_valid, resp_valid, resp_nak, resp_buf_y, irq;
    logic [EP_W-1:0] in_tok_ep, in_done_ep;
    logic [ADDR_W-1:0] resp_addr;
    logic [LEN_W-1:0] resp_len;
    int miscompares = 0;
    int total_checks = 0;
    always #10 sys_clk = ~sys_clk;
    uibc_top uibc_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_tok_valid(in_tok_valid), .in_tok_ep(in_tok_ep), .resp_valid(resp_valid), .resp_nak(resp_nak),
        .resp_buf_y(resp_buf_y), .resp_addr(resp_addr), .resp_len(resp_len), .in_done_valid(in_done_valid),
        .in_done_ep(in_done_ep), .irq(irq));
    uibc_host_model uibc_host_model_i (.sys_clk(sys_clk), .in_tok_valid(in_tok_valid), .in_tok_ep(in_tok_ep),
        .in_done_valid(in_done_valid), .in_done_ep(in_done_ep), .resp_valid(resp_valid));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [PADDR_W-1:0] ad(input int e, input int b);
        return PADDR_W'(e * 32 + b * 4);
    endfunction
    task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) miscompares++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [PADDR_W-1:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask
    // token, then the whole answer; a nak leaves buffer select, address and length unchecked
    task automatic rsp(input int ep, input logic nak, input logic y, input logic [10:0] a, input logic [11:0] len);
        logic got;
        uibc_host_model_i.tok(EP_W'(ep), got);
        chk({31'h0, got}, 32'h1);
        chk({31'h0, resp_nak}, {31'h0, nak});
        if (!nak) begin
            chk({31'h0, resp_buf_y}, {31'h0, y});
            chk({21'h0, resp_addr}, {21'h0, a});
            chk({20'h0, resp_len}, {20'h0, len});
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(ad(1, 0), 32'h0, 1'b0);
        rd(ad(7, 2), 32'h0, 1'b0);
        wr(ad(7, 1), 32'hab);
        rd(ad(7, 1), 32'hab, 1'b0);
        wr(ad(7, 3), 32'h55);
        rd(ad(7, 3), 32'h55, 1'b0);
        wr(ad(7, 6), 32'h55);
        rd(ad(7, 6), 32'h0, 1'b1);
        $display("test regs done");
        wr(ad(1, 2), 32'h05);
        wr(ad(1, 4), 32'h12);
        wr(IRQ_MASK_OFF, 32'h02);
        rsp(1, 1'b0, 1'b0, 11'h090, 12'h005);
        uibc_host_model_i.done(3'h1);
        rd(ad(1, 2), 32'h85, 1'b0);
        chk({31'h0, irq}, 32'h1);
        rsp(1, 1'b1, 1'b0, 11'h0, 12'h0);
        wr(ad(1, 2), 32'h05);
        rsp(1, 1'b0, 1'b0, 11'h090, 12'h005);
        rd(IRQ_STATUS_OFF, 32'h02, 1'b0);
        wr(IRQ_STATUS_OFF, 32'h02);
        rd(IRQ_STATUS_OFF, 32'h0, 1'b0);
        chk({31'h0, irq}, 32'h0);
        $display("test bulk done");
        wr(ad(2, 5), 32'h43);
        wr(ad(2, 2), 32'h0a);
        wr(ad(2, 4), 32'h80);
        rsp(2, 1'b0, 1'b0, 11'h400, 12'h028);
        uibc_host_model_i.done(3'h2);
        rd(ad(2, 2), 32'h8a, 1'b0);
        rsp(2, 1'b0, 1'b0, 11'h400, 12'h028);
        wr(ad(2, 5), 32'h4f);
        wr(ad(2, 2), 32'h7f);
        rsp(2, 1'b0, 1'b0, 11'h400, 12'h7f0);
        wr(ad(2, 5), 32'h40);
        rsp(2, 1'b0, 1'b0, 11'h400, 12'h07f);
        wr(ad(2, 5), 32'h5f);
        rsp(2, 1'b0, 1'b0, 11'h400, 12'hfe0);
        $display("test iso done");
        wr(ad(3, 5), 32'h10);
        wr(ad(3, 4), 32'h01);
        wr(ad(3, 1), 32'hff);
        wr(ad(3, 2), 32'h02);
        wr(ad(3, 0), 32'h04);
        rsp(3, 1'b0, 1'b0, 11'h008, 12'h002);
        uibc_host_model_i.done(3'h3);
        rsp(3, 1'b0, 1'b1, 11'h7f8, 12'h004);
        uibc_host_model_i.done(3'h3);
        rd(ad(3, 0), 32'h84, 1'b0);
        rd(ad(3, 2), 32'h82, 1'b0);
        rsp(3, 1'b1, 1'b0, 11'h0, 12'h0);
        $display("test dual done");
        // leave the selector at the second buffer, then reset mid-run
        wr(ad(3, 2), 32'h02);
        rsp(3, 1'b0, 1'b0, 11'h008, 12'h002);
        uibc_host_model_i.done(3'h3);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(ad(3, 0), 32'h0, 1'b0);
        rd(ad(3, 5), 32'h0, 1'b0);
        chk({31'h0, irq}, 32'h0);
        wr(ad(3, 5), 32'h10);
        wr(ad(3, 2), 32'h03);
        rsp(3, 1'b0, 1'b0, 11'h000, 12'h003);
        $display("test reset done");
        final_report();
    end
endmodule // uibc_top_tb_top
